/* verilog/sadc_defs.svh */
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

// ---------------------------------------------------------------------
// Control register layout
// ---------------------------------------------------------------------
`define SADC_CTRL_MASK_BIT  7
`define SADC_CTRL_EOC_BIT   6
`define SADC_CTRL_START_BIT 5
`define SADC_CTRL_PWR_BIT   4
`define SADC_CTRL_RST       8'h40

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define SADC_DIV_RATIO      12
`define SADC_CONV_TIME_NS   70000
`define SADC_OSC_PERIOD_NS  125
`define SADC_CONV_TICKS     \
  (`SADC_CONV_TIME_NS / `SADC_OSC_PERIOD_NS / `SADC_DIV_RATIO)
`define SADC_BIT_TICKS      5
`define SADC_RES_BITS       8
`define SADC_MIDSCALE       8'h80

`endif

/* verilog/sadc_pkg.sv */
`default_nettype none
package sadc_pkg;

  // -------------------------------------------------------------------
  // Control side
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    SADC_C_IDLE  = 3'b001,
    SADC_C_ARMED = 3'b010,
    SADC_C_RUN   = 3'b100
  } sadc_ctrl_st_t;

  typedef struct packed {
    sadc_ctrl_st_t state;
    logic          done_irq_mask;
    logic          eoc;
    logic          power_select;
    logic [7:0]    result;
    logic [7:0]    ctrl_rd;
    logic          irq;
    logic          start_p;
    logic          abort_p;
  } sadc_ctrl_s_t;

  // -------------------------------------------------------------------
  // Engine side
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    SADC_E_IDLE   = 3'b001,
    SADC_E_SAMPLE = 3'b010,
    SADC_E_CONV   = 3'b100
  } sadc_eng_st_t;

  typedef struct packed {
    sadc_eng_st_t state;
    logic [3:0]   div;
    logic [5:0]   ticks;
    logic [7:0]   trial;
    logic [7:0]   mask;
    logic [2:0]   sync;
    logic         cmp;
    logic         done;
  } sadc_eng_s_t;

endpackage : sadc_pkg
`default_nettype wire

/* verilog/sadc_sar_if.sv */
`default_nettype none
interface sadc_sar_if;
  logic       start;
  logic       abort;
  logic       busy;
  logic       done;
  logic [7:0] trial;

  modport ctrl (output start, output abort,
                input busy, input done, input trial);
  modport eng  (input start, input abort,
                output busy, output done, output trial);
endinterface : sadc_sar_if
`default_nettype wire

/* verilog/sadc_sar_engine.sv */
`include "sadc_defs.svh"
`default_nettype none
module sadc_sar_engine
  import sadc_pkg::*;
#(
  parameter int DIV_RATIO  = `SADC_DIV_RATIO,
  parameter int CONV_TICKS = `SADC_CONV_TICKS,
  parameter int BIT_TICKS  = `SADC_BIT_TICKS
) (
  input  wire logic   core_clk_i,
  input  wire logic   rst_n_i,
  input  wire logic   cmp_i,
  sadc_sar_if.eng     bus
);

  localparam int SAMPLE_TICKS = CONV_TICKS - `SADC_RES_BITS * BIT_TICKS;

  if (DIV_RATIO < 2 || DIV_RATIO > 16 || BIT_TICKS < 1 ||
      BIT_TICKS > 64 || SAMPLE_TICKS < 1 ||
      SAMPLE_TICKS > 63) begin : g_chk
    $error("sadc_sar_engine: unsupported timing parameters");
  end

  localparam logic [3:0] DIV_LAST = 4'(DIV_RATIO - 1);
  localparam logic [5:0] SMP_LAST = 6'(SAMPLE_TICKS - 1);
  localparam logic [5:0] BIT_LAST = 6'(BIT_TICKS - 1);

  localparam sadc_eng_s_t RST = '{state: SADC_E_IDLE, div: 4'h0,
    ticks: 6'h00, trial: 8'h00, mask: 8'h00, sync: 3'h0, cmp: 1'b0,
    done: 1'b0};

  sadc_eng_s_t s;
  sadc_eng_s_t next_s;
  logic        tick;
  logic [7:0]  kept;

  // -------------------------------------------------------------------
  // Successive approximation
  // -------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    // The comparator is analog and asynchronous, so it is filtered.
    next_s.sync = {s.sync[1:0], cmp_i};
    if (s.sync[1] == s.sync[2]) begin
      next_s.cmp = s.sync[2];
    end
    tick = (s.div == DIV_LAST); // R01
    kept = s.cmp ? s.trial : (s.trial & ~s.mask);
    if (bus.start) begin
      next_s.state = SADC_E_SAMPLE;
      next_s.div   = 4'h0;
      next_s.ticks = 6'h00;
      next_s.trial = `SADC_MIDSCALE; // R17
      next_s.mask  = `SADC_MIDSCALE;
    end else if (bus.abort) begin
      next_s.state = SADC_E_IDLE;
    end else if (s.state != SADC_E_IDLE) begin
      next_s.div = tick ? 4'h0 : s.div + 4'h1; // R01
      if (tick) begin
        next_s.ticks = s.ticks + 6'h01;
      end
      case (s.state)
        SADC_E_SAMPLE: begin
          if (tick && s.ticks == SMP_LAST) begin
            next_s.state = SADC_E_CONV;
            next_s.ticks = 6'h00;
          end
        end
        SADC_E_CONV: begin
          if (tick && s.ticks == BIT_LAST) begin
            next_s.ticks = 6'h00;
            next_s.mask  = s.mask >> 1;
            next_s.trial = kept | (s.mask >> 1); // R01
            if (s.mask == 8'h01) begin
              next_s.state = SADC_E_IDLE;
              next_s.done  = 1'b1; // R02
            end
          end
        end
        default: begin
          next_s.state = SADC_E_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= RST;
    end else begin
      s <= next_s;
    end
  end

  assign bus.busy  = (s.state != SADC_E_IDLE);
  assign bus.done  = s.done;
  assign bus.trial = s.trial;

  property p_div_bound;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s.div <= DIV_LAST;
  endproperty
  a_div_bound: assert property (p_div_bound) // R01
    else $error("conversion clock divider ran past its last count");

endmodule : sadc_sar_engine
`default_nettype wire

/* verilog/sadc_ctrl.sv */
//
// Behaviour
// R01: 8-bit successive approximation, conversion clock is oscillator over 12.
// R02: Full conversion lasts about 70 us at an 8 MHz oscillator.
// R03: Writing start one begins a conversion and clears the done flag.
// R04: Done flag sets at completion; result is valid only while it is set.
// R05: One conversion per start write, never restarting on its own.
// R06: Start while converting abandons the old conversion and begins anew.
// R07: Start bit is write-only and reads back as zero.
// R08: Done flag raises the interrupt, passed only while the mask bit is one.
// R09: Power select zero keeps the converter down; one lets it convert. A start pulse on the power-down edge keeps the engine busy one cycle.
// R10: Software sets power select at least one instruction before starting.
// R11: WAIT does not power the converter off; software must do that.
// R12: Reset stops conversion, loads control with 40h, masks the interrupt.
// R13: Software selects at most one analog input line at a time.
// R14: With the WAIT option, a requested start waits until WAIT is entered.
// R15: With the WAIT option, software executes WAIT right after starting.
// R16: Software should stop the timer in WAIT and wake on the interrupt.
// R17: Codes split the rail span into 256 equal steps.
// R18: Control holds mask bit 7, done 6, start 5, power 4, rest unused.
// R19: A separate read-only register shows the 8-bit result.
// R20: Writing start as zero leaves conversion and done flag untouched.
//
`include "sadc_defs.svh"
`default_nettype none
module sadc_ctrl
  import sadc_pkg::*;
#(
  parameter int DIV_RATIO  = `SADC_DIV_RATIO,
  parameter int CONV_TICKS = `SADC_CONV_TICKS,
  parameter int BIT_TICKS  = `SADC_BIT_TICKS
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       sync_opt_i,
  input  wire logic       wait_entered_i,
  input  wire logic       cmp_i,
  output logic      [7:0] conv_control_reg_o,
  output logic      [7:0] result_o,
  output logic      [7:0] dac_code_o,
  output logic            power_o,
  output logic            irq_o
);

  localparam logic [7:0] CTRL_RST = `SADC_CTRL_RST;

  localparam sadc_ctrl_s_t RST = '{state: SADC_C_IDLE,
    done_irq_mask: CTRL_RST[`SADC_CTRL_MASK_BIT],
    eoc:           CTRL_RST[`SADC_CTRL_EOC_BIT],
    power_select:  CTRL_RST[`SADC_CTRL_PWR_BIT],
    result: 8'h00, ctrl_rd: CTRL_RST, irq: 1'b0,
    start_p: 1'b0, abort_p: 1'b0};

  sadc_ctrl_s_t s;
  sadc_ctrl_s_t next_s;
  logic         wr_start;
  logic         wr_pdown;

  sadc_sar_if sar ();

  // -------------------------------------------------------------------
  // Converter engine
  // -------------------------------------------------------------------
  sadc_sar_engine #(
    .DIV_RATIO  (DIV_RATIO),
    .CONV_TICKS (CONV_TICKS),
    .BIT_TICKS  (BIT_TICKS)
  ) u_engine (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .cmp_i      (cmp_i),
    .bus        (sar.eng)
  );

  // -------------------------------------------------------------------
  // Control register and sequencing
  // -------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.start_p = 1'b0;
    next_s.abort_p = 1'b0;
    wr_start = wr_en_i && wr_data_i[`SADC_CTRL_START_BIT];
    wr_pdown = wr_en_i && !wr_data_i[`SADC_CTRL_PWR_BIT];
    if (wr_en_i) begin
      next_s.done_irq_mask = wr_data_i[`SADC_CTRL_MASK_BIT]; // R08
      next_s.power_select  = wr_data_i[`SADC_CTRL_PWR_BIT]; // R09 R11
    end
    if (wr_pdown) begin
      // Powering down drops any conversion; the flag keeps its value.
      next_s.abort_p = 1'b1; // R09
      next_s.state   = SADC_C_IDLE;
    end else if (wr_start && s.power_select) begin
      // A start needs power already on, so the converter has settled.
      next_s.eoc     = 1'b0; // R03 R10
      next_s.abort_p = 1'b1; // R06
      if (sync_opt_i && !wait_entered_i) begin
        next_s.state = SADC_C_ARMED; // R14 R15
      end else begin
        next_s.state   = SADC_C_RUN; // R03
        next_s.start_p = 1'b1; // R06
      end
    end else begin
      case (s.state)
        SADC_C_ARMED: begin
          if (wait_entered_i) begin
            next_s.state   = SADC_C_RUN; // R14
            next_s.start_p = 1'b1;
          end
        end
        SADC_C_RUN: begin
          if (sar.done) begin
            next_s.eoc    = 1'b1; // R04
            next_s.result = sar.trial; // R19
            next_s.state  = SADC_C_IDLE; // R05
          end
        end
        SADC_C_IDLE: begin
          next_s.state = SADC_C_IDLE; // R05 R20
        end
        default: begin
          next_s.state = SADC_C_IDLE;
        end
      endcase
    end
    next_s.ctrl_rd = {next_s.done_irq_mask, next_s.eoc, 1'b0,
                      next_s.power_select, 4'h0}; // R07 R18
    next_s.irq     = next_s.done_irq_mask && next_s.eoc; // R08
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= RST; // R12
    end else begin
      s <= next_s;
    end
  end

  assign sar.start          = s.start_p;
  // A power-down write stops the engine at its own edge unless a start pulse lands on that edge, in which case the
  // engine stays busy for one cycle after the power flag reads zero.
  assign sar.abort          = s.abort_p || wr_pdown; // R09
  assign conv_control_reg_o = s.ctrl_rd;
  assign result_o           = s.result;
  assign dac_code_o         = sar.trial;
  assign power_o            = s.power_select;
  assign irq_o              = s.irq;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  property p_start_clears;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_en_i && wr_data_i[`SADC_CTRL_START_BIT] &&
      wr_data_i[`SADC_CTRL_PWR_BIT] && s.power_select
      |=> !conv_control_reg_o[`SADC_CTRL_EOC_BIT];
  endproperty
  a_start_clears: assert property (p_start_clears) // R03
    else $error("start write did not clear the done flag");

  property p_start_reads_zero;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(wr_en_i) |=> !conv_control_reg_o[`SADC_CTRL_START_BIT];
  endproperty
  a_start_reads_zero: assert property (p_start_reads_zero) // R07
    else $error("start bit read back as one");

  property p_irq_gated;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    irq_o == (conv_control_reg_o[`SADC_CTRL_MASK_BIT] &&
              conv_control_reg_o[`SADC_CTRL_EOC_BIT]);
  endproperty
  a_irq_gated: assert property (p_irq_gated) // R08
    else $error("interrupt does not follow flag and mask");

  property p_zero_start_keeps;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_en_i && !wr_data_i[`SADC_CTRL_START_BIT] &&
      conv_control_reg_o[`SADC_CTRL_EOC_BIT]
      |=> conv_control_reg_o[`SADC_CTRL_EOC_BIT];
  endproperty
  a_zero_start_keeps: assert property (p_zero_start_keeps) // R20
    else $error("writing start as zero cleared the done flag");

  property p_power_idle;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !power_o |-> !sar.busy;
  endproperty
  a_power_idle: assert property (p_power_idle) // R09
    else $error("converter busy while powered down");

  property p_single_shot;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(conv_control_reg_o[`SADC_CTRL_EOC_BIT]) |-> !sar.busy &&
      s.state == SADC_C_IDLE;
  endproperty
  a_single_shot: assert property (p_single_shot) // R05
    else $error("converter kept running after completion");

  property p_restart;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_en_i && wr_data_i[`SADC_CTRL_START_BIT] &&
      wr_data_i[`SADC_CTRL_PWR_BIT] && s.power_select && !sync_opt_i
      |=> ##1 sar.busy ##1 (sar.busy && !sar.done) [*8];
  endproperty
  a_restart: assert property (p_restart) // R06
    else $error("start did not launch a fresh conversion");

  property p_wait_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s.state == SADC_C_ARMED && !wait_entered_i && !wr_en_i
      |=> s.state == SADC_C_ARMED && !s.start_p;
  endproperty
  a_wait_hold: assert property (p_wait_hold) // R14
    else $error("conversion launched before WAIT was entered");

  property p_result_valid;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(conv_control_reg_o[`SADC_CTRL_EOC_BIT]) |->
      result_o == $past(sar.trial);
  endproperty
  a_result_valid: assert property (p_result_valid) // R04
    else $error("result not captured with the done flag");

endmodule : sadc_ctrl
`default_nettype wire

/* bench/sadc_analog_src.sv */
`default_nettype none
module sadc_analog_src (
  input  wire logic       clk_i,
  input  wire logic       powered_i,
  input  wire logic [7:0] dac_code_i,
  input  wire logic [7:0] level_i,
  output logic            cmp_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Comparator on the one selected analog line
  // ---------------------------------------------------------------
  logic chatter = 1'b0;

  // An unpowered comparator gives no usable answer, so it chatters.
  always @(posedge clk_i) begin
    chatter <= ~chatter;
  end

  // Only one line feeds the comparator; a code step is 1/256 of rails.
  assign cmp_o = powered_i ? (level_i >= dac_code_i) : chatter;
endmodule : sadc_analog_src
`default_nettype wire

/* bench/sar_adc_conversion_control_bench.sv */
`default_nettype none
module sar_adc_conversion_control_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  // Small counts keep the run short: 18 ticks of 4 cycles each.
  localparam int CONV = 72;
  logic       core_clk_i     = 1'b0;
  logic       rst_n_i        = 1'b0;
  logic       wr_en_i        = 1'b0;
  logic [7:0] wr_data_i      = 8'h00;
  logic       sync_opt_i     = 1'b0;
  logic       wait_entered_i = 1'b0;
  logic [7:0] level          = 8'h00;
  logic       cmp_i;
  logic [7:0] ctrl;
  logic [7:0] result;
  logic [7:0] dac_code;
  logic       power;
  logic       irq;
  int         err_total      = 0;
  int         checks_done    = 0;
  int         n;
  logic [7:0] corner [4]     = '{8'h00, 8'hFF, 8'h7F, 8'h80};

  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  sadc_ctrl #(.DIV_RATIO(4), .CONV_TICKS(18), .BIT_TICKS(2)) u_dut (
    .core_clk_i        (core_clk_i),
    .rst_n_i           (rst_n_i),
    .wr_en_i           (wr_en_i),
    .wr_data_i         (wr_data_i),
    .sync_opt_i        (sync_opt_i),
    .wait_entered_i    (wait_entered_i),
    .cmp_i             (cmp_i),
    .conv_control_reg_o(ctrl),
    .result_o          (result),
    .dac_code_o        (dac_code),
    .power_o           (power),
    .irq_o             (irq)
  );

  sadc_analog_src u_src (
    .clk_i     (core_clk_i),
    .powered_i (power),
    .dac_code_i(dac_code),
    .level_i   (level),
    .cmp_o     (cmp_i)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] sar_ref(input logic [7:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      if (v >= (c | (8'h01 << b))) c = c | (8'h01 << b);
    end
    return c;
  endfunction : sar_ref

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // Leaves two settled cycles after the write edge before returning.
  task automatic wr(input logic [7:0] d);
    @(negedge core_clk_i);
    wr_en_i   = 1'b1;
    wr_data_i = d;
    @(negedge core_clk_i);
    wr_en_i   = 1'b0;
    @(negedge core_clk_i);
    @(negedge core_clk_i);
  endtask : wr

  task automatic wait_done(input int lim, output int cyc);
    cyc = 0;
    while (ctrl[6] !== 1'b1 && cyc < lim) begin
      @(negedge core_clk_i);
      cyc++;
    end
  endtask : wait_done

  task automatic conv(input logic [7:0] v, input logic m);
    int cyc;
    level = v;
    wr({m, 7'h30});
    chk(ctrl, {m, 7'h10});
    chk({7'h00, irq}, 8'h00);
    chk(dac_code, 8'h80);
    wait_done(200, cyc);
    chk(8'(cyc >= CONV - 8 && cyc <= CONV + 8), 8'h01);
    chk(result, sar_ref(v));
    chk(ctrl, {m, 7'h50});
    chk({7'h00, irq}, {7'h00, m});
  endtask : conv

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(90257));
    repeat (2) @(negedge core_clk_i);
    chk(ctrl, 8'h40);
    chk(result, 8'h00);
    chk({6'h00, power, irq}, 8'h00);
    @(negedge core_clk_i);
    rst_n_i = 1'b1;
    wr(8'h20);
    chk(ctrl, 8'h40);
    wr(8'h10);
    chk({7'h00, power}, 8'h01);
    chk(ctrl, 8'h50);
    for (int i = 0; i < 4; i++) conv(corner[i], i[0]);
    repeat (12) conv(8'($urandom_range(255)), 1'($urandom_range(1)));
    conv(8'h5A, 1'b1);
    repeat (100) @(negedge core_clk_i);
    chk(ctrl, 8'hD0);
    chk(result, 8'h5A);
    level = 8'h33;
    wr(8'hB0);
    repeat (30) @(negedge core_clk_i);
    conv(8'hC4, 1'b1);
    level = 8'hA5;
    wr(8'hB0);
    wr(8'h90);
    chk(ctrl, 8'h90);
    wait_done(200, n);
    chk(result, 8'hA5);
    wr(8'hB0);
    wr(8'h80);
    chk({7'h00, power}, 8'h00);
    wait_done(200, n);
    chk(ctrl, 8'h80);
    chk({7'h00, irq}, 8'h00);
    wr(8'h10);
    sync_opt_i = 1'b1;
    level      = 8'h6B;
    wr(8'hB0);
    wait_done(150, n);
    chk(ctrl, 8'h90);
    chk({7'h00, irq}, 8'h00);
    wait_entered_i = 1'b1;
    wait_done(200, n);
    chk(8'(n >= CONV - 8 && n <= CONV + 8), 8'h01);
    chk(result, 8'h6B);
    chk({7'h00, irq}, 8'h01);
    chk({7'h00, power}, 8'h01);
    sync_opt_i = 1'b0;
    conv(8'h2C, 1'b0);
    wait_entered_i = 1'b0;
    wr(8'hB0);
    repeat (20) @(negedge core_clk_i);
    rst_n_i = 1'b0;
    @(negedge core_clk_i);
    chk(ctrl, 8'h40);
    chk({6'h00, power, irq}, 8'h00);
    rst_n_i = 1'b1;
    repeat (100) @(negedge core_clk_i);
    chk(ctrl, 8'h40);
    give_verdict();
  end

  // The tests need about 2200 cycles; a hang is cut well beyond that.
  initial begin
    repeat (40000) @(posedge core_clk_i);
    err_total++;
    give_verdict();
  end
endmodule : sar_adc_conversion_control_bench
`default_nettype wire
